// *** src/chop_route_defs.svh ***
// register indices, field positions and reset values of the configuration bank
`ifndef CHOP_ROUTE_DEFS_SVH
`define CHOP_ROUTE_DEFS_SVH

`define IDX_W            14
`define IDX_STATUS       14'h2100
`define IDX_BG_CHOP      14'h2106
`define IDX_DIFF         14'h210c
`define IDX_ROUTE_10_11  14'h2451
`define IDX_ROUTE_8_9    14'h2452
`define IDX_ROUTE_6_7    14'h2453
`define IDX_ROUTE_4_5    14'h2454
`define IDX_ROUTE_2_3    14'h2455
`define IDX_REF_CHOP     14'h2709

`define BG_CHOP_LSB      2
`define DIFF_LSB         4
`define ROUTE_LO_LSB     0
`define ROUTE_HI_LSB     4
`define REF_CHOP_LSB     6

`define BG_CHOP_RST      2'h0
`define REF_CHOP_RST     2'h0
`define DIFF_RST         4'h0
`define ROUTE_RST        3'h0
`define CHOP_STATE_RST   1'b1

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// *** src/chop_route_pkg.sv ***
// types shared by the chop and pin routing configuration bank
package chop_route_pkg;
`include "chop_route_defs.svh"

   typedef enum logic [1:0] {
      BG_TOGGLE_A = 2'b00,
      BG_POSITIVE = 2'b01,
      BG_REVERSED = 2'b10,
      BG_TOGGLE_B = 2'b11
   } bg_chop_e;

   typedef enum logic [1:0] {
      REF_AUTO     = 2'b00,
      REF_POSITIVE = 2'b01,
      REF_NEGATIVE = 2'b10,
      REF_UNUSED   = 2'b11
   } ref_chop_e;

   typedef enum logic [2:0] {
      ROUTE_NONE     = 3'b000,
      ROUTE_RESERVED = 3'b001,
      ROUTE_TIMER0   = 3'b010,
      ROUTE_TIMER1   = 3'b011
   } route_e;

   typedef logic [`IDX_W-1:0] index_t;

   function automatic index_t addr_to_index(input logic [15:0] addr);
      return addr[15:2];
   endfunction

endpackage

// *** src/reg_access_if.sv ***
// byte-wide register access between the bus port and the bank
`timescale 1ns/1ps
interface reg_access_if;
   import chop_route_pkg::*;
   logic       wr_stb;
   index_t     wr_index;
   logic [7:0] wr_byte;
   logic       wr_ok;
   index_t     rd_index;
   logic [7:0] rd_byte;
   logic       rd_ok;
   modport port (output wr_stb, output wr_index, output wr_byte, input wr_ok,
                 output rd_index, input rd_byte, input rd_ok);
   modport bank (input wr_stb, input wr_index, input wr_byte, output wr_ok,
                 input rd_index, output rd_byte, output rd_ok);
endinterface

// *** src/axil_reg_port.sv ***
// axi4-lite slave that turns bus transfers into byte accesses of the bank
`timescale 1ns/1ps
module axil_reg_port
   import chop_route_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [15:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [15:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   reg_access_if.port       ra
);
   typedef struct packed {
      logic       aw_held;
      index_t     aw_idx;
      logic       w_held;
      logic [7:0] w_byte;
      logic       w_lane0;
      logic       bvalid;
      logic [1:0] bresp;
      logic       rvalid;
      logic [7:0] rbyte;
      logic [1:0] rresp;
   } port_s;

   port_s s;
   port_s next_s;

   assign awready     = !s.aw_held && !s.bvalid;
   assign wready      = !s.w_held && !s.bvalid;
   assign arready     = !s.rvalid;
   assign bvalid      = s.bvalid;
   assign bresp       = s.bresp;
   assign rvalid      = s.rvalid;
   assign rresp       = s.rresp;
   assign rdata       = {24'h000000, s.rbyte};
   // a write without lane 0 stores nothing but is still answered
   assign ra.wr_stb   = s.aw_held && s.w_held && !s.bvalid && s.w_lane0;
   assign ra.wr_index = s.aw_idx;
   assign ra.wr_byte  = s.w_byte;
   assign ra.rd_index = addr_to_index(araddr);

   always_comb begin
      next_s = s;
      if (awvalid && awready) begin
         next_s.aw_held = 1'b1;
         next_s.aw_idx  = addr_to_index(awaddr);
      end
      if (wvalid && wready) begin
         next_s.w_held  = 1'b1;
         next_s.w_byte  = wdata[7:0];
         next_s.w_lane0 = wstrb[0];
      end
      if (s.aw_held && s.w_held && !s.bvalid) begin
         next_s.aw_held = 1'b0;
         next_s.w_held  = 1'b0;
         next_s.bvalid  = 1'b1;
         next_s.bresp   = ra.wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_s.rvalid = 1'b1;
         next_s.rbyte  = ra.rd_ok ? ra.rd_byte : 8'h00;
         next_s.rresp  = ra.rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// *** src/chop_sequencer.sv ***
// bandgap chop state stepped on rising edges of the multiplexer sync pulse
`timescale 1ns/1ps
module chop_sequencer
   import chop_route_pkg::*;
(
   input  wire logic     aclk,
   input  wire logic     aresetn,
   input  wire logic     multiplexer_sync_pulse,
   input  wire logic     accumulation_end,
   input  wire bg_chop_e mode,
   output logic          chop_state
);
   typedef struct packed {
      logic sync_d;
      logic chop;
   } seq_s;

   seq_s s;
   seq_s next_s;
   logic sync_rise;

   assign chop_state = s.chop;
   assign sync_rise  = multiplexer_sync_pulse && !s.sync_d;

   always_comb begin
      next_s        = s;
      next_s.sync_d = multiplexer_sync_pulse;
      if (sync_rise) begin
         case (mode)
            BG_POSITIVE: next_s.chop = 1'b1;
            BG_REVERSED: next_s.chop = 1'b0;
            BG_TOGGLE_A,
            BG_TOGGLE_B: next_s.chop = accumulation_end ? s.chop : !s.chop;
            default:     next_s.chop = s.chop;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= {1'b0, `CHOP_STATE_RST};
      end else begin
         s <= next_s;
      end
   end
endmodule

// *** src/frontend_chop_and_dio_route_cfg.sv ***
// configuration bank for front end chopping, differential pairs and pin routing
//
// Overview of operation
// - bandgap chop changes only on sync rising edge
// - 01 positive, 10 reversed, 00/11 toggle
// - toggle skipped at accumulation-ending sync edge
// - reference chop: 00 auto, 01 positive, 10 negative
// - four pair enables, reset zero, single-ended
// - pins 2..11 each own 3-bit selector, reset 0
// - pins sharing a resource are ORed together
// - codes: 0 none, 1 reserved, 2 timer0, 3 timer1
//
// index map, byte address four times the index:
//   2100 status, read-only: [0] chop state, [1] timer0, [2] timer1
//   2106 bandgap chop select in [3:2]
//   210c pair enables in [7:4], bit 4 pair 0-1 up to bit 7 pair 6-7
//   2451 pin10 route in [2:0], pin11 route in [6:4]
//   2452 pin8 and pin9, 2453 pin6 and pin7, same layout
//   2454 pin4 and pin5, 2455 pin2 and pin3, same layout
//   2709 reference chop select in [7:6]
// unmapped indices answer slave error and read zero; the reference
// chop code is only held and driven out, auto chopping lies outside
`timescale 1ns/1ps
module frontend_chop_and_dio_route_cfg
   import chop_route_pkg::*;
#(
   parameter int FIRST_PIN = 2,
   parameter int LAST_PIN  = 11
)
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [15:0] awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [15:0] araddr,
   input  wire logic [2:0]  arprot,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        multiplexer_sync_pulse,
   input  wire logic        accumulation_end,
   input  wire logic [11:2] general_pin_in,
   output logic             bandgap_chop,
   output logic [1:0]       reference_chop_select,
   output logic             pair01_differential_enable,
   output logic             pair23_differential_enable,
   output logic             pair45_differential_enable,
   output logic             pair67_differential_enable,
   output logic             timer0_clock_gate_input,
   output logic             timer1_clock_gate_input
);
   import chop_route_pkg::*;

   // selector map and read-back layout are fixed to pins 2..11
   if (FIRST_PIN != 2) begin : g_bad_first_pin
      $error("FIRST_PIN must be 2 to match the selector map");
   end
   if (LAST_PIN != 11) begin : g_bad_last_pin
      $error("LAST_PIN must be 11 to match the selector map");
   end

   typedef struct packed {
      bg_chop_e          bg_chop_sel;
      ref_chop_e         ref_chop_sel;
      logic [3:0]        diff_en;
      logic [11:2][2:0]  route;
      logic              timer0;
      logic              timer1;
   } bank_s;

   bank_s        s;
   bank_s        next_s;
   reg_access_if ra ();
   logic         chop_state;
   logic         t0_any;
   logic         t1_any;

   // prot bits carry no meaning here; every access is treated alike
   axil_reg_port u_port (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .ra      (ra.port)
   );

   chop_sequencer u_chop (
      .aclk                   (aclk),
      .aresetn                (aresetn),
      .multiplexer_sync_pulse (multiplexer_sync_pulse),
      .accumulation_end       (accumulation_end),
      .mode                   (s.bg_chop_sel),
      .chop_state             (chop_state)
   );

   function automatic logic is_mapped(input index_t idx);
      case (idx)
         `IDX_STATUS,
         `IDX_BG_CHOP,
         `IDX_DIFF,
         `IDX_ROUTE_10_11,
         `IDX_ROUTE_8_9,
         `IDX_ROUTE_6_7,
         `IDX_ROUTE_4_5,
         `IDX_ROUTE_2_3,
         `IDX_REF_CHOP: is_mapped = 1'b1;
         default:       is_mapped = 1'b0;
      endcase
   endfunction

   // one selector pair per byte: even pin low nibble, odd pin high nibble
   function automatic logic [7:0] route_pair(input logic [2:0] lo, input logic [2:0] hi);
      route_pair = {1'b0, hi, 1'b0, lo};
   endfunction

   function automatic logic [7:0] read_byte(input index_t idx, input bank_s b,
                                            input logic chop);
      read_byte = 8'h00;
      case (idx)
         `IDX_STATUS:      read_byte = {5'h00, b.timer1, b.timer0, chop};
         `IDX_BG_CHOP:     read_byte = {4'h0, b.bg_chop_sel, 2'h0};
         `IDX_DIFF:        read_byte = {b.diff_en, 4'h0};
         `IDX_ROUTE_10_11: read_byte = route_pair(b.route[10], b.route[11]);
         `IDX_ROUTE_8_9:   read_byte = route_pair(b.route[8], b.route[9]);
         `IDX_ROUTE_6_7:   read_byte = route_pair(b.route[6], b.route[7]);
         `IDX_ROUTE_4_5:   read_byte = route_pair(b.route[4], b.route[5]);
         `IDX_ROUTE_2_3:   read_byte = route_pair(b.route[2], b.route[3]);
         `IDX_REF_CHOP:    read_byte = {b.ref_chop_sel, 6'h00};
         default:          read_byte = 8'h00;
      endcase
   endfunction

   assign ra.wr_ok   = is_mapped(ra.wr_index);
   assign ra.rd_ok   = is_mapped(ra.rd_index);
   assign ra.rd_byte = read_byte(ra.rd_index, s, chop_state);

   // resource decode, each resource the OR of all pins routed to it
   always_comb begin
      t0_any = 1'b0;
      t1_any = 1'b0;
      for (int p = 2; p <= 11; p++) begin
         case (route_e'(s.route[p]))
            ROUTE_TIMER0: t0_any = t0_any | general_pin_in[p];
            ROUTE_TIMER1: t1_any = t1_any | general_pin_in[p];
            // none and reserved codes feed nothing
            default: begin
            end
         endcase
      end
   end

   // writes land on the commit edge, the same edge that raises the port's bvalid
   always_comb begin
      next_s        = s;
      next_s.timer0 = t0_any;
      next_s.timer1 = t1_any;
      if (ra.wr_stb) begin
         case (ra.wr_index)
            `IDX_BG_CHOP: begin
               next_s.bg_chop_sel = bg_chop_e'(ra.wr_byte[`BG_CHOP_LSB +: 2]);
            end
            `IDX_DIFF: begin
               next_s.diff_en = ra.wr_byte[`DIFF_LSB +: 4];
            end
            `IDX_ROUTE_10_11: begin
               next_s.route[10] = ra.wr_byte[`ROUTE_LO_LSB +: 3];
               next_s.route[11] = ra.wr_byte[`ROUTE_HI_LSB +: 3];
            end
            `IDX_ROUTE_8_9: begin
               next_s.route[8] = ra.wr_byte[`ROUTE_LO_LSB +: 3];
               next_s.route[9] = ra.wr_byte[`ROUTE_HI_LSB +: 3];
            end
            `IDX_ROUTE_6_7: begin
               next_s.route[6] = ra.wr_byte[`ROUTE_LO_LSB +: 3];
               next_s.route[7] = ra.wr_byte[`ROUTE_HI_LSB +: 3];
            end
            `IDX_ROUTE_4_5: begin
               next_s.route[4] = ra.wr_byte[`ROUTE_LO_LSB +: 3];
               next_s.route[5] = ra.wr_byte[`ROUTE_HI_LSB +: 3];
            end
            `IDX_ROUTE_2_3: begin
               next_s.route[2] = ra.wr_byte[`ROUTE_LO_LSB +: 3];
               next_s.route[3] = ra.wr_byte[`ROUTE_HI_LSB +: 3];
            end
            `IDX_REF_CHOP: begin
               next_s.ref_chop_sel = ref_chop_e'(ra.wr_byte[`REF_CHOP_LSB +: 2]);
            end
            `IDX_STATUS: begin
               // live state only; a write is answered and dropped
            end
            // unmapped indices store nothing
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s.bg_chop_sel  <= bg_chop_e'(`BG_CHOP_RST);
         s.ref_chop_sel <= ref_chop_e'(`REF_CHOP_RST);
         s.diff_en      <= `DIFF_RST;
         for (int p = 2; p <= 11; p++) begin
            s.route[p] <= `ROUTE_RST;
         end
         s.timer0       <= 1'b0;
         s.timer1       <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // timers lag the pins one cycle so every output leaves a flip-flop
   assign bandgap_chop               = chop_state;
   assign reference_chop_select      = s.ref_chop_sel;
   assign pair01_differential_enable = s.diff_en[0];
   assign pair23_differential_enable = s.diff_en[1];
   assign pair45_differential_enable = s.diff_en[2];
   assign pair67_differential_enable = s.diff_en[3];
   assign timer0_clock_gate_input    = s.timer0;
   assign timer1_clock_gate_input    = s.timer1;
endmodule

// *** sim/cfg_checker_asserts.sv ***
// port-level assertions for the chop and pin routing configuration bank
`timescale 1ns/1ps
module cfg_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        multiplexer_sync_pulse,
   input wire logic [11:2] general_pin_in,
   input wire logic        bandgap_chop,
   input wire logic [1:0]  reference_chop_select,
   input wire logic        pair01_differential_enable,
   input wire logic        pair23_differential_enable,
   input wire logic        pair45_differential_enable,
   input wire logic        pair67_differential_enable,
   input wire logic        timer0_clock_gate_input,
   input wire logic        timer1_clock_gate_input
);
   logic [5:0] cfg;
   logic [1:0] tmr;
   assign cfg = {reference_chop_select, pair67_differential_enable, pair45_differential_enable,
                 pair23_differential_enable, pair01_differential_enable};
   assign tmr = {timer1_clock_gate_input, timer0_clock_gate_input};
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence resp_wait;
      bvalid && !bready;
   endsequence
   a_chop_hold: assert property (!$rose(multiplexer_sync_pulse) |=> $stable(bandgap_chop))
      else $error("chop state moved without a sync rising edge");
   a_cfg_by_write: assert property ($past(aresetn) && $changed(cfg) |-> $rose(bvalid))
      else $error("configuration output changed outside a write commit");
   a_reset_values: assert property ($rose(aresetn) |-> bandgap_chop && cfg == 6'h0 && tmr == 2'h0)
      else $error("outputs not at reset values");
   a_idle_timers: assert property (general_pin_in == 10'h0 |=> tmr == 2'h0)
      else $error("timer input high with all pins low");
   a_write_answer: assert property (wr_taken |=> !bvalid ##1 bvalid)
      else $error("write response not two cycles after the transfer");
   a_write_hold: assert property (resp_wait |=> bvalid && $stable(bresp))
      else $error("write response dropped before bready");
   a_write_block: assert property (bvalid |-> !awready && !wready)
      else $error("write accepted while a response is pending");
   a_read_answer: assert property (arvalid && arready |=> rvalid && rdata[31:8] == 24'h0)
      else $error("read data not one cycle after the address");
   a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data dropped before rready");
endmodule

bind frontend_chop_and_dio_route_cfg cfg_checker cfg_checker_i (.*);

// *** sim/test_frontend_chop_and_dio_route_cfg.sv ***
// self-checking bench for the chop and pin routing configuration bank
`timescale 1ns/1ps
`include "chop_route_defs.svh"
module test_frontend_chop_and_dio_route_cfg;
   import chop_route_pkg::*;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, bandgap_chop;
   logic        multiplexer_sync_pulse, accumulation_end;
   logic        pair01_differential_enable, pair23_differential_enable;
   logic        pair45_differential_enable, pair67_differential_enable;
   logic        timer0_clock_gate_input, timer1_clock_gate_input;
   logic [15:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [2:0]  awprot, arprot;
   logic [1:0]  bresp, rresp, reference_chop_select;
   logic [11:2] general_pin_in;
   int          n_fail = 0;
   int          checks_done = 0;
   index_t      regs[8] = '{`IDX_BG_CHOP, `IDX_DIFF, `IDX_ROUTE_10_11, `IDX_ROUTE_8_9,
                            `IDX_ROUTE_6_7, `IDX_ROUTE_4_5, `IDX_ROUTE_2_3, `IDX_REF_CHOP};
   logic [7:0]  mask[8] = '{8'h0c, 8'hf0, 8'h77, 8'h77, 8'h77, 8'h77, 8'h77, 8'hc0};

   frontend_chop_and_dio_route_cfg frontend_chop_and_dio_route_cfg_i (.*);

   always #5 aclk = ~aclk;

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input index_t idx, input logic [7:0] val, input logic [1:0] resp);
      int t;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, val};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (t = 0; t < 50; t++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      check("bresp", 32'({1'b1, resp}), 32'({bvalid, bresp}));
   endtask

   task automatic rd(input index_t idx, input logic [7:0] val, input logic [1:0] resp);
      int t;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (t = 0; t < 50; t++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      check("rresp", 32'({1'b1, resp}), 32'({rvalid, rresp}));
      check("rdata", {24'h0, val}, rdata);
   endtask

   task automatic pins(input logic [9:0] v);
      @(posedge aclk);
      general_pin_in <= v;
      repeat (2) @(posedge aclk);
   endtask

   // sync held high several cycles: only its rising edge may step the chop
   task automatic sync(input logic acc);
      @(posedge aclk);
      multiplexer_sync_pulse <= 1'b1;
      accumulation_end <= acc;
      @(posedge aclk);
      accumulation_end <= 1'b0;
      repeat (3) @(posedge aclk);
      multiplexer_sync_pulse <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic t_regs;
      foreach (regs[i]) rd(regs[i], 8'h00, `RESP_OKAY);
      rd(`IDX_STATUS, 8'h01, `RESP_OKAY);
      wr(`IDX_STATUS, 8'h06, `RESP_OKAY);
      rd(`IDX_STATUS, 8'h01, `RESP_OKAY);
      foreach (regs[i]) begin
         wr(regs[i], 8'hff, `RESP_OKAY);
         rd(regs[i], mask[i], `RESP_OKAY);
         wr(regs[i], 8'h00, `RESP_OKAY);
      end
      wr(14'h2107, 8'hff, `RESP_SLVERR);
      rd(14'h2107, 8'h00, `RESP_SLVERR);
      // lane 0 off: answered but nothing stored
      wstrb <= 4'he;
      wr(`IDX_DIFF, 8'hf0, `RESP_OKAY);
      wstrb <= 4'hf;
      rd(`IDX_DIFF, 8'h00, `RESP_OKAY);
   endtask

   task automatic t_ports;
      for (int c = 0; c < 3; c++) begin
         wr(`IDX_REF_CHOP, 8'(c << 6), `RESP_OKAY);
         check("ref_sel", 32'(c), 32'(reference_chop_select));
      end
      for (int i = 0; i < 4; i++) begin
         wr(`IDX_DIFF, 8'(8'h10 << i), `RESP_OKAY);
         check("pairs", 32'(1 << i), 32'({pair67_differential_enable,
               pair45_differential_enable, pair23_differential_enable,
               pair01_differential_enable}));
      end
      wr(`IDX_DIFF, 8'h00, `RESP_OKAY);
      wr(`IDX_REF_CHOP, 8'h00, `RESP_OKAY);
   endtask

   task automatic t_chop;
      logic [1:0] modes[4] = '{2'b10, 2'b01, 2'b00, 2'b11};
      logic       exp;
      exp = 1'b1;
      foreach (modes[i]) begin
         wr(`IDX_BG_CHOP, {4'h0, modes[i], 2'b00}, `RESP_OKAY);
         check("chop_idle", 32'(exp), 32'(bandgap_chop));
         for (int a = 0; a < 2; a++) begin
            sync(a[0]);
            if (modes[i] == 2'b01) exp = 1'b1;
            else if (modes[i] == 2'b10) exp = 1'b0;
            else if (a == 0) exp = ~exp;
            check("chop", 32'(exp), 32'(bandgap_chop));
         end
      end
   endtask

   task automatic t_route;
      index_t idx;
      for (int p = 2; p < 12; p++) begin
         idx = `IDX_ROUTE_2_3 - index_t'((p - 2) / 2);
         for (int c = 2; c < 4; c++) begin
            wr(idx, 8'(c << ((p % 2) * 4)), `RESP_OKAY);
            pins(10'(1 << (p - 2)));
            check("timers", 32'(c - 1), 32'({timer1_clock_gate_input,
                  timer0_clock_gate_input}));
            pins(~10'(1 << (p - 2)));
            check("timers", 0, 32'({timer1_clock_gate_input, timer0_clock_gate_input}));
         end
         wr(idx, 8'h00, `RESP_OKAY);
      end
      // pins 2,3 to timer0, pin4 to timer1, pin5 left unrouted
      wr(`IDX_ROUTE_2_3, 8'h22, `RESP_OKAY);
      wr(`IDX_ROUTE_4_5, 8'h03, `RESP_OKAY);
      pins(10'h002);
      check("timers", 1, 32'({timer1_clock_gate_input, timer0_clock_gate_input}));
      pins(10'h008);
      check("timers", 0, 32'({timer1_clock_gate_input, timer0_clock_gate_input}));
      pins(10'h00f);
      check("timers", 3, 32'({timer1_clock_gate_input, timer0_clock_gate_input}));
      rd(`IDX_STATUS, 8'h07, `RESP_OKAY);
   endtask

   task automatic test_done;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      test_done();
   end

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wdata, awprot, arprot} = '0;
      wstrb = 4'hf;
      multiplexer_sync_pulse = 1'b0;
      accumulation_end = 1'b0;
      general_pin_in = 10'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_ports();
      t_chop();
      t_route();
      test_done();
   end
endmodule
